// [core/rscd_regs.vh]
`ifndef RSCD_REGS_VH
`define RSCD_REGS_VH

// Serial bus rail addresses and register indices.
`define RSCD_RAIL_MAIN        4'h0
`define RSCD_RAIL_AUX_LO      4'h1
`define RSCD_RAIL_AUX_HI      4'h2
`define RSCD_RAIL_SYS         4'hd
`define RSCD_REG_CURRENT      8'h15
`define RSCD_REG_SYS_POWER    8'h1b
`define RSCD_REG_MAX_CURRENT  8'h21
`define RSCD_REG_HP_CAP       8'h50

// Serial frame layout: rail address bits, header bits (address and register), whole frame bits.
`define RSCD_ADDR_BITS        5'd4
`define RSCD_HDR_BITS         5'd12
`define RSCD_FRAME_BITS       5'd20

// Address and slew strap decode.
`define RSCD_AS_LAST_CODE     4'hb
`define RSCD_AS_AUX_HI_FIRST  4'h6
`define RSCD_SLEW_SLOW        6'h0a
`define RSCD_SLEW_MID         6'h1e
`define RSCD_SLEW_FAST        6'h30

// Boot level encodings: 0 V, 1.05 V and 1.8 V.
`define RSCD_BOOT_OFF         2'h0
`define RSCD_BOOT_1V05        2'h1
`define RSCD_BOOT_1V8         2'h2

// Programming strap bit positions.
`define RSCD_PP_DOUBLE_LSB    3
`define RSCD_PP_ACOUSTIC      2
`define RSCD_PP_SPREAD        1
`define RSCD_PP_SHED          0

// High power capability field: power scaling [4:2], current [1:0].
`define RSCD_HP_CAP_SINGLE    5'h08
`define RSCD_HP_CAP_DOUBLE    5'h0d

// Modulation modes derived from the power state.
`define RSCD_MOD_DUAL_EDGE    2'h0
`define RSCD_MOD_RIPPLE_CCM   2'h1
`define RSCD_MOD_RIPPLE_DCM   2'h2
`define RSCD_MOD_STANDBY      2'h3

// Power state codes.
`define RSCD_PS_ZERO          3'h0
`define RSCD_PS_ONE           3'h1
`define RSCD_PS_TWO           3'h2
`define RSCD_PS_THREE         3'h3
`define RSCD_PS_FOUR          3'h4

`endif

// [core/rscd_top.v]
`timescale 1ns/10ps
`include "rscd_regs.vh"

module rscd_top #(
    parameter CODE_W = 4
) (
    // Clock and reset
    input  wire              clk_in,
    input  wire              arst_n_in,
    // Strap codes from the resistor measurement front end
    input  wire [CODE_W-1:0] addr_slew_code_in,
    input  wire [CODE_W-1:0] boot_step_code_in,
    input  wire [CODE_W-1:0] prog_pin_code_in,
    input  wire              strap_valid_in,
    // Digitized telemetry
    input  wire [7:0]        system_power_input_in,
    input  wire [7:0]        aux_current_input_in,
    input  wire [7:0]        aux_current_full_scale_in,
    input  wire [9:0]        main_current_in,
    input  wire [9:0]        max_current_limit_in,
    input  wire [7:0]        aux_rail_current_in,
    // Run time control
    input  wire [2:0]        power_state_in,
    input  wire              shed_cfg_en_in,
    input  wire              spread_cfg_en_in,
    input  wire              acoustic_cfg_en_in,
    // Serial bus pins
    input  wire              ser_clk_in,
    input  wire              ser_sel_n_in,
    input  wire              ser_data_in,
    output reg               ser_data_out,
    output reg               ser_data_oe_n_out,
    // Decoded configuration
    output reg               config_done_out,
    output reg  [3:0]        main_addr_out,
    output reg  [3:0]        aux_addr_out,
    output reg  [5:0]        slew_rate_out,
    output reg               thermal_alert_fast_out,
    output reg  [1:0]        main_boot_voltage_out,
    output reg  [1:0]        aux_boot_voltage_out,
    output reg               main_step_10mv_out,
    output reg               aux_step_10mv_out,
    output reg               double_current_lsb_out,
    output reg  [4:0]        hp_cap_out,
    // Feature state
    output reg  [1:0]        modulation_mode_out,
    output reg               phase_shed_active_out,
    output reg               spread_active_out,
    output reg               acoustic_active_out
);

////////////////////////////////////////////////////////////////////////////////

    function [7:0] sat8;
        input [9:0] v;
        begin
            sat8 = (v[9:8] != 2'h0) ? 8'hff : v[7:0];
        end
    endfunction

    function [7:0] scale_fs;
        input [7:0] raw;
        input [7:0] fs;
        reg   [15:0] prod;
        begin
            prod     = raw * fs;
            prod     = prod / 16'h00ff;
            scale_fs = prod[7:0];
        end
    endfunction

    function [1:0] main_boot;
        input [3:0] c;
        begin
            case (c)
                4'h2, 4'h3, 4'ha, 4'hb: main_boot = `RSCD_BOOT_1V05;
                4'h6, 4'h7, 4'hd, 4'hf: main_boot = `RSCD_BOOT_1V8;
                default:                main_boot = `RSCD_BOOT_OFF;
            endcase
        end
    endfunction

    function [1:0] aux_boot;
        input [3:0] c;
        begin
            case (c)
                4'h1, 4'h3, 4'he, 4'hf: aux_boot = `RSCD_BOOT_1V05;
                4'h5, 4'h7, 4'h9, 4'hb: aux_boot = `RSCD_BOOT_1V8;
                default:                aux_boot = `RSCD_BOOT_OFF;
            endcase
        end
    endfunction

////////////////////////////////////////////////////////////////////////////////

    reg         rst_meta_reg;
    reg         rst_sync_reg;
    wire        rst_n;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

////////////////////////////////////////////////////////////////////////////////

    // Codes above the last table entry are treated as the last entry.
    wire [3:0] as_code = (addr_slew_code_in[3:0] > `RSCD_AS_LAST_CODE) ?
                         `RSCD_AS_LAST_CODE : addr_slew_code_in[3:0];
    wire [3:0] bs_code = boot_step_code_in[3:0];
    wire [3:0] pp_code = prog_pin_code_in[3:0];
    wire [1:0] as_mod3 = (as_code == 4'h0 || as_code == 4'h3 ||
                          as_code == 4'h6 || as_code == 4'h9) ? 2'h0 :
                         (as_code == 4'h1 || as_code == 4'h4 ||
                          as_code == 4'h7 || as_code == 4'ha) ? 2'h1 : 2'h2;
    wire       as_fast = (as_code < 4'h3) ||
                         (as_code >= 4'h6 && as_code < 4'h9);

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            config_done_out        <= 1'b0;
            main_addr_out          <= `RSCD_RAIL_MAIN;
            aux_addr_out           <= `RSCD_RAIL_AUX_LO;
            slew_rate_out          <= `RSCD_SLEW_SLOW;
            thermal_alert_fast_out <= 1'b0;
            main_boot_voltage_out  <= `RSCD_BOOT_OFF;
            aux_boot_voltage_out   <= `RSCD_BOOT_OFF;
            main_step_10mv_out     <= 1'b0;
            aux_step_10mv_out      <= 1'b0;
            double_current_lsb_out <= 1'b0;
            hp_cap_out             <= `RSCD_HP_CAP_SINGLE;
        end else if (!config_done_out && strap_valid_in) begin
            config_done_out <= 1'b1;
            main_addr_out   <= `RSCD_RAIL_MAIN;
            aux_addr_out    <= (as_code < `RSCD_AS_AUX_HI_FIRST) ?
                               `RSCD_RAIL_AUX_LO : `RSCD_RAIL_AUX_HI;
            slew_rate_out   <= (as_mod3 == 2'h0) ? `RSCD_SLEW_SLOW :
                               (as_mod3 == 2'h1) ? `RSCD_SLEW_MID :
                               `RSCD_SLEW_FAST;
            thermal_alert_fast_out <= as_fast;
            main_boot_voltage_out  <= main_boot(bs_code);
            aux_boot_voltage_out   <= aux_boot(bs_code);
            main_step_10mv_out     <= bs_code[2];
            aux_step_10mv_out      <= bs_code[2] ^ bs_code[3];
            double_current_lsb_out <= pp_code[`RSCD_PP_DOUBLE_LSB];
            hp_cap_out <= pp_code[`RSCD_PP_DOUBLE_LSB] ?
                          `RSCD_HP_CAP_DOUBLE : `RSCD_HP_CAP_SINGLE;
        end
    end

    reg        shed_permit_reg;
    reg        spread_permit_reg;
    reg        acoustic_permit_reg;

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            shed_permit_reg     <= 1'b0;
            spread_permit_reg   <= 1'b0;
            acoustic_permit_reg <= 1'b0;
        end else if (!config_done_out && strap_valid_in) begin
            shed_permit_reg     <= pp_code[`RSCD_PP_SHED];
            spread_permit_reg   <= pp_code[`RSCD_PP_SPREAD];
            acoustic_permit_reg <= pp_code[`RSCD_PP_ACOUSTIC];
        end
    end

////////////////////////////////////////////////////////////////////////////////

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            modulation_mode_out   <= `RSCD_MOD_STANDBY;
            phase_shed_active_out <= 1'b0;
            spread_active_out     <= 1'b0;
            acoustic_active_out   <= 1'b0;
        end else begin
            case (power_state_in)
                `RSCD_PS_ZERO:
                    modulation_mode_out <= `RSCD_MOD_DUAL_EDGE;
                `RSCD_PS_ONE:
                    modulation_mode_out <= `RSCD_MOD_RIPPLE_CCM;
                `RSCD_PS_TWO, `RSCD_PS_THREE:
                    modulation_mode_out <= `RSCD_MOD_RIPPLE_DCM;
                default:
                    modulation_mode_out <= `RSCD_MOD_STANDBY;
            endcase
            phase_shed_active_out <= shed_permit_reg && shed_cfg_en_in &&
                                     (power_state_in == `RSCD_PS_ZERO);
            spread_active_out   <= spread_permit_reg &&
                                   spread_cfg_en_in;
            acoustic_active_out <= acoustic_permit_reg &&
                                   acoustic_cfg_en_in;
        end
    end

////////////////////////////////////////////////////////////////////////////////

    // Serial pins cross in through two flip-flops each.
    reg  [2:0] ser_meta_reg;
    reg  [2:0] ser_sync_reg;
    reg        ser_clk_last_reg;
    wire       s_clk   = ser_sync_reg[2];
    wire       s_sel_n = ser_sync_reg[1];
    wire       s_data  = ser_sync_reg[0];
    wire       s_rise  = s_clk && !ser_clk_last_reg;

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ser_meta_reg     <= 3'h2;
            ser_sync_reg     <= 3'h2;
            ser_clk_last_reg <= 1'b0;
        end else begin
            ser_meta_reg     <= {ser_clk_in, ser_sel_n_in, ser_data_in};
            ser_sync_reg     <= ser_meta_reg;
            ser_clk_last_reg <= s_clk;
        end
    end

    reg  [4:0]  bit_cnt_reg;
    reg  [11:0] hdr_reg;
    reg  [7:0]  shift_reg;
    reg  [7:0]  read_data;
    reg         read_hit;
    wire [11:0] hdr_full = {hdr_reg[10:0], s_data};
    wire [3:0]  rail     = hdr_full[11:8];
    wire [7:0]  index    = hdr_full[7:0];

    always @* begin
        read_data = 8'h00;
        read_hit  = 1'b1;
        if (rail == `RSCD_RAIL_SYS) begin
            if (index == `RSCD_REG_SYS_POWER)
                read_data = system_power_input_in;
            else if (index == `RSCD_REG_CURRENT)
                read_data = scale_fs(aux_current_input_in,
                                     aux_current_full_scale_in);
        end else if (rail == main_addr_out) begin
            if (index == `RSCD_REG_CURRENT)
                read_data = double_current_lsb_out ?
                            sat8({1'b0, main_current_in[9:1]}) :
                            sat8(main_current_in);
            else if (index == `RSCD_REG_MAX_CURRENT)
                read_data = double_current_lsb_out ?
                            sat8({1'b0, max_current_limit_in[9:1]}) :
                            sat8(max_current_limit_in);
            else if (index == `RSCD_REG_HP_CAP)
                read_data = {3'h0, hp_cap_out};
        end else if (rail == aux_addr_out) begin
            if (index == `RSCD_REG_CURRENT)
                read_data = aux_rail_current_in;
            else if (index == `RSCD_REG_HP_CAP)
                read_data = {3'h0, `RSCD_HP_CAP_SINGLE};
        end else begin
            read_hit = 1'b0;
        end
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg       <= 5'h00;
            hdr_reg           <= 12'h000;
            shift_reg         <= 8'h00;
            ser_data_out      <= 1'b0;
            ser_data_oe_n_out <= 1'b1;
        end else if (s_sel_n) begin
            bit_cnt_reg       <= 5'h00;
            ser_data_out      <= 1'b0;
            ser_data_oe_n_out <= 1'b1;
        end else if (s_rise && bit_cnt_reg < `RSCD_FRAME_BITS) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg < `RSCD_HDR_BITS) begin
                hdr_reg <= hdr_full;
                if (bit_cnt_reg == `RSCD_HDR_BITS - 5'h01) begin
                    shift_reg         <= {read_data[6:0], 1'b0};
                    ser_data_out      <= read_hit & read_data[7];
                    ser_data_oe_n_out <= !read_hit;
                end
            end else if (bit_cnt_reg == `RSCD_FRAME_BITS - 5'h01) begin
                ser_data_out      <= 1'b0;
                ser_data_oe_n_out <= 1'b1;
            end else begin
                shift_reg    <= {shift_reg[6:0], 1'b0};
                ser_data_out <= shift_reg[7] & !ser_data_oe_n_out;
            end
        end
    end

endmodule // rscd_top

// [dv/rscd_props.sv]
`timescale 1ns/10ps
module rscd_props #(
    parameter CODE_W = 4
) (
    input wire              clk_in,
    input wire              arst_n_in,
    input wire [CODE_W-1:0] addr_slew_code_in,
    input wire [2:0]        power_state_in,
    input wire              shed_cfg_en_in,
    input wire              spread_cfg_en_in,
    input wire              acoustic_cfg_en_in,
    input wire              ser_sel_n_in,
    input wire              ser_data_oe_n_out,
    input wire              config_done_out,
    input wire [3:0]        main_addr_out,
    input wire [3:0]        aux_addr_out,
    input wire [5:0]        slew_rate_out,
    input wire              thermal_alert_fast_out,
    input wire              double_current_lsb_out,
    input wire [4:0]        hp_cap_out,
    input wire [1:0]        modulation_mode_out,
    input wire              phase_shed_active_out,
    input wire              spread_active_out,
    input wire              acoustic_active_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    chk_main_addr: assert property (config_done_out |->
        main_addr_out == 4'h0)
        else $error("main rail address not zero");
    chk_aux_addr: assert property ($rose(config_done_out) |->
        aux_addr_out == ((addr_slew_code_in > 5) ? 4'h2 : 4'h1))
        else $error("aux rail address wrong");
    chk_slew_fast: assert property ($rose(config_done_out) &&
        addr_slew_code_in < 12 |-> thermal_alert_fast_out ==
        (addr_slew_code_in % 6 < 3) && slew_rate_out ==
        ((addr_slew_code_in % 3 == 0) ? 6'h0a :
        (addr_slew_code_in % 3 == 1) ? 6'h1e : 6'h30))
        else $error("slew or fast mode decode wrong");
    chk_cfg_held: assert property (config_done_out &&
        $past(config_done_out) |-> $stable(slew_rate_out) &&
        $stable(hp_cap_out) && $stable(aux_addr_out))
        else $error("captured configuration changed");
    chk_hp_cap: assert property (config_done_out |-> hp_cap_out ==
        (double_current_lsb_out ? 5'h0d : 5'h08))
        else $error("capability field wrong");
    chk_mode_ccm: assert property (config_done_out &&
        power_state_in == 3'h1 |=> modulation_mode_out == 2'h1)
        else $error("ripple ccm mode wrong");
    chk_mode_dcm: assert property (config_done_out &&
        power_state_in inside {3'h2, 3'h3} |=> modulation_mode_out == 2'h2)
        else $error("dcm mode wrong");
    chk_shed_gate: assert property (phase_shed_active_out |->
        $past(power_state_in) == 3'h0 && $past(shed_cfg_en_in))
        else $error("shedding outside state zero");
    chk_feat_gate: assert property (!spread_cfg_en_in &&
        !acoustic_cfg_en_in |=> !spread_active_out && !acoustic_active_out)
        else $error("feature active without setting");
    chk_oe_idle: assert property (ser_sel_n_in [*6] |-> ser_data_oe_n_out)
        else $error("data driven outside a frame");
endmodule // rscd_props

// [dv/rscd_host_model.sv]
`timescale 1ns/10ps
module rscd_host_model (
    input  wire clk_in,
    input  wire dev_data_in,
    input  wire dev_oe_n_in,
    output reg  ser_clk_out = 1'b0,
    output reg  ser_sel_n_out = 1'b1,
    output wire ser_line_out
);
    reg hdrv = 1'b0;
    reg hbit = 1'b0;
    reg idle_tgl = 1'b0;
    // An undriven line toggles so that no stale bit can pass as data.
    assign ser_line_out = !dev_oe_n_in ? dev_data_in : hdrv ? hbit : idle_tgl;
    always @(posedge clk_in) idle_tgl <= ~idle_tgl;
    task read_reg(input [3:0] rail, input [7:0] idx, output [7:0] val,
                  output ans);
        integer n;
        reg [11:0] hdr;
        begin
            hdr = {rail, idx};
            ans = 0;
            val = 0;
            #40 ser_sel_n_out = 0;
            hdrv = 1;
            for (n = 1; n <= 20; n = n + 1) begin
                if (n <= 12) hbit = hdr[12-n];
                #32 ser_clk_out = 1;
                if (n > 12) begin
                    val = {val[6:0], ser_line_out};
                    ans = ans | !dev_oe_n_in;
                end
                #32 ser_clk_out = 0;
                if (n == 12) hdrv = 0;
            end
            #40 ser_sel_n_out = 1;
        end
    endtask
endmodule // rscd_host_model

// [dv/rscd_top_tb.sv]
`timescale 1ns/10ps
module rscd_top_tb;
    reg clk_in = 0, arst_n_in = 0, strap_valid_in = 0, shed_cfg_en_in = 0;
    reg spread_cfg_en_in = 0, acoustic_cfg_en_in = 0;
    reg [3:0] addr_slew_code_in = 0, boot_step_code_in = 0;
    reg [3:0] prog_pin_code_in = 0;
    reg [2:0] power_state_in = 0;
    reg [7:0] system_power_input_in = 8'h5a, aux_current_input_in = 8'hc8;
    reg [7:0] aux_current_full_scale_in = 8'h80, aux_rail_current_in = 8'hc8;
    reg [9:0] main_current_in = 10'h190, max_current_limit_in = 10'h12c;
    wire ser_clk_in, ser_sel_n_in, ser_data_in, ser_data_out;
    wire ser_data_oe_n_out, config_done_out, thermal_alert_fast_out;
    wire main_step_10mv_out, aux_step_10mv_out, double_current_lsb_out;
    wire phase_shed_active_out, spread_active_out, acoustic_active_out;
    wire [3:0] main_addr_out, aux_addr_out;
    wire [5:0] slew_rate_out;
    wire [1:0] main_boot_voltage_out, aux_boot_voltage_out;
    wire [1:0] modulation_mode_out;
    wire [4:0] hp_cap_out;
    integer err_total = 0, num_checks = 0, i;
    // Boot levels per code, {main, aux}, code 0 in the low nibble.
    localparam [63:0] BOOT = 64'h9180_6420_a820_5410;
    rscd_top i_rscd_top (.*);
    rscd_host_model i_rscd_host_model (.clk_in(clk_in),
        .dev_data_in(ser_data_out), .dev_oe_n_in(ser_data_oe_n_out),
        .ser_clk_out(ser_clk_in), .ser_sel_n_out(ser_sel_n_in),
        .ser_line_out(ser_data_in));
    initial forever #4 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        begin
            $display("checks %0d errors %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task ck(input string nm, input [9:0] e, input [9:0] g);
        begin
            num_checks = num_checks + 1;
            if (e !== g) begin
                err_total = err_total + 1;
                $display("ERROR %0s exp %0h got %0h", nm, e, g);
            end
        end
    endtask
    task rd(input [3:0] rail, input [7:0] idx, input [7:0] e, input ea);
        reg [7:0] v;
        reg a;
        begin
            i_rscd_host_model.read_reg(rail, idx, v, a);
            ck("answer", ea, a);
            if (ea) ck("read", e, v);
        end
    endtask
    task run_case(input integer c);
        integer n, p;
        reg [3:0] a;
        reg [5:0] s;
        reg d;
        begin
            a = c % 12;
            d = c[3];
            s = (a % 3 == 0) ? 6'h0a : (a % 3 == 1) ? 6'h1e : 6'h30;
            @(posedge clk_in);
            arst_n_in <= 0;
            strap_valid_in <= 0;
            addr_slew_code_in <= a;
            boot_step_code_in <= c;
            prog_pin_code_in <= c;
            repeat (2) @(posedge clk_in);
            #1 ck("mode_rst", 3, modulation_mode_out);
            @(posedge clk_in);
            arst_n_in <= 1;
            repeat (4) @(posedge clk_in);
            strap_valid_in <= 1;
            n = 0;
            while (config_done_out !== 1'b1) begin
                if (n == 20) begin
                    err_total = err_total + 1;
                    end_sim;
                end
                @(posedge clk_in);
                #1 n = n + 1;
            end
            ck("main_addr", 0, main_addr_out);
            ck("aux_addr", a > 5 ? 2 : 1, aux_addr_out);
            ck("slew", s, slew_rate_out);
            ck("fast", a % 6 < 3, thermal_alert_fast_out);
            ck("boot", BOOT[4*c+:4],
               {main_boot_voltage_out, aux_boot_voltage_out});
            ck("step", {c[2], c[2] ^ c[3]},
               {main_step_10mv_out, aux_step_10mv_out});
            ck("dbl", d, double_current_lsb_out);
            ck("hp_cap", d ? 10'h0d : 10'h08, hp_cap_out);
            @(posedge clk_in);
            addr_slew_code_in <= ~a;
            prog_pin_code_in <= ~c;
            repeat (3) @(posedge clk_in);
            #1 ck("hold_slew", s, slew_rate_out);
            ck("hold_dbl", d, double_current_lsb_out);
            for (p = 0; p < 5; p = p + 1) begin
                @(posedge clk_in);
                power_state_in <= p;
                {shed_cfg_en_in, spread_cfg_en_in, acoustic_cfg_en_in} <= 3'h7;
                repeat (2) @(posedge clk_in);
                #1 ck("mode", p == 0 ? 0 : p == 1 ? 1 : p < 4 ? 2 : 3,
                      modulation_mode_out);
                ck("shed", p == 0 && c[0], phase_shed_active_out);
                ck("spread", c[1], spread_active_out);
                ck("acoustic", c[2], acoustic_active_out);
            end
            @(posedge clk_in);
            power_state_in <= 0;
            {shed_cfg_en_in, spread_cfg_en_in, acoustic_cfg_en_in} <= 3'h0;
            repeat (2) @(posedge clk_in);
            #1 ck("feat_off", 0, {phase_shed_active_out, spread_active_out,
                  acoustic_active_out});
            rd(4'hd, 8'h15, 8'd100, 1);
            rd(4'hd, 8'h1b, 8'h5a, 1);
            rd(4'h0, 8'h15, d ? 8'd200 : 8'd255, 1);
            rd(4'h0, 8'h21, d ? 8'd150 : 8'd255, 1);
            rd(4'h0, 8'h50, d ? 8'h0d : 8'h08, 1);
            rd(a > 5 ? 4'h2 : 4'h1, 8'h15, 8'hc8, 1);
            rd(a > 5 ? 4'h1 : 4'h2, 8'h15, 8'h00, 0);
            rd(4'h0, 8'h33, 8'h00, 1);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        arst_n_in <= 1;
        for (i = 0; i < 16; i = i + 1) run_case(i);
        end_sim;
    end
endmodule // rscd_top_tb
bind rscd_top rscd_props #(.CODE_W(CODE_W)) i_rscd_props (.*);
